// >>> bench/direct_motion_trigger_queue_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module direct_motion_trigger_queue_tb
  import direct_motion_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst, regWrEn, regRdEn, regRdValid, trigSelWrEn, motorIdle, motorContinuous, motionDone;
  logic        cmdLoad, execIncremental, direct_cmd_ready, direct_queue_full, launch_echo;
  logic [15:0] regAddr, regWrData, regRdData, trigSelWrData, execKind, execCurrent;
  logic [31:0] execPosition, execSpeed, execAccel, execDecel;
  int          fail_count = 0;
  int          checked = 0;
  int          loads = 0;
  always #4 clk = ~clk;
  always @(posedge clk) if (cmdLoad === 1'b1) loads <= loads + 1;
  direct_motion_trigger_queue dut (.clk(clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
    .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid), .trigSelWrEn(trigSelWrEn),
    .trigSelWrData(trigSelWrData), .motorIdle(motorIdle), .motorContinuous(motorContinuous), .motionDone(motionDone),
    .cmdLoad(cmdLoad), .execKind(execKind), .execPosition(execPosition), .execSpeed(execSpeed),
    .execAccel(execAccel), .execDecel(execDecel), .execCurrent(execCurrent), .execIncremental(execIncremental),
    .direct_cmd_ready(direct_cmd_ready), .direct_queue_full(direct_queue_full), .launch_echo(launch_echo));
  host_model host (.clk(clk), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .regRdValid(regRdValid));
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic setSel(input logic [15:0] v);
    @(posedge clk);
    #1;
    trigSelWrEn = 1'b1;
    trigSelWrData = v;
    @(posedge clk);
    #1;
    trigSelWrEn = 1'b0;
  endtask : setSel
  task automatic pulseDone;
    @(posedge clk);
    #1;
    motionDone = 1'b1;
    @(posedge clk);
    #1;
    motionDone = 1'b0;
  endtask : pulseDone
  task automatic t_reset;
    logic [15:0] d;
    logic        v;
    `CHK(direct_cmd_ready, 1'b1)
    `CHK(direct_queue_full, 1'b0)
    `CHK(execIncremental, 1'b1)
    `CHK(execAccel, 32'h000F4240)
    `CHK(execKind, 16'h0002)
    `CHK(execDecel, 32'h000F4240)
    `CHK(execCurrent, 16'h03E8)
    host.wr(REG_FIXED_OUT, 16'hFFFF);
    host.rd(REG_FIXED_OUT, d, v);
    `CHK(v, 1'b1)
    `CHK(d, 16'h0040)
    host.rd(16'h0200, d, v);
    `CHK(d, 16'h0000)
    $display("test reset done");
  endtask : t_reset
  task automatic t_edge;
    logic [15:0] d;
    logic        v;
    int          base;
    base = loads;
    host.readyCheck(v);
    `CHK(v, 1'b1)
    host.wr(REG_POS_LOW, 16'h1388);
    host.wr(REG_POS_HIGH, 16'h0001);
    host.wr(REG_SPEED_LOW, 16'h07D0);
    tick(3);
    `CHK(loads - base, 0)
    host.launch(1'b0);
    tick(2);
    `CHK(loads - base, 1)
    `CHK(execPosition, 32'h00011388)
    `CHK(execSpeed, 32'h000007D0)
    `CHK(launch_echo, 1'b1)
    host.rd(REG_FIXED_OUT, d, v);
    `CHK(d, 16'h0140)
    host.drop(1'b0);
    tick(3);
    `CHK(loads - base, 1)
    $display("test edge done");
  endtask : t_edge
  task automatic t_level;
    logic [15:0] codes[8] = '{LAUNCH_STROBE_SEL_KIND, LAUNCH_STROBE_SEL_POS, LAUNCH_STROBE_SEL_SPEED, LAUNCH_STROBE_SEL_ACCEL,
      LAUNCH_STROBE_SEL_DECEL, LAUNCH_STROBE_SEL_CURRENT, LAUNCH_STROBE_SEL_OFF, LAUNCH_STROBE_SEL_ANY};
    logic [15:0] selA[8] = '{REG_MOTION_KIND, REG_POS_LOW, REG_SPEED_LOW, REG_ACCEL_LOW,
      REG_DECEL_LOW, REG_RUN_CURRENT, REG_POS_LOW, REG_POS_LOW};
    int          base;
    int          on;
    for (int i = 0; i < 8; i++)
    begin
      on = (i != 6);
      setSel(codes[i]);
      base = loads;
      host.launch(1'b1);
      tick(3);
      `CHK(loads - base, on)
      host.wr((i == 5) ? REG_SPEED_LOW : REG_RUN_CURRENT, 16'h0200 + i);
      tick(3);
      `CHK(loads - base, on + (i == 7))
      host.wr(selA[i], 16'h0300 + i);
      host.wr(selA[i], 16'h0300 + i);
      tick(3);
      `CHK(loads - base, 2 * on + (i == 7))
      host.drop(1'b1);
    end
    $display("test level done");
  endtask : t_level
  task automatic t_buffer;
    int base;
    setSel(LAUNCH_STROBE_SEL_ANY);
    host.wr(REG_MOTION_KIND, KIND_INCREMENTAL_CMD);
    host.wr(REG_FORWARD, FORWARD_BUFFER);
    motorIdle = 1'b0;
    host.wr(REG_POS_LOW, 16'h0AAA);
    base = loads;
    host.launch(1'b0);
    tick(3);
    `CHK(loads - base, 0)
    `CHK(direct_queue_full, 1'b1)
    `CHK(direct_cmd_ready, 1'b0)
    host.drop(1'b0);
    host.wr(REG_POS_LOW, 16'h0BBB);
    host.launch(1'b0);
    host.drop(1'b0);
    pulseDone;
    tick(3);
    `CHK(loads - base, 1)
    `CHK(execPosition[15:0], 16'h0AAA)
    `CHK(execIncremental, 1'b1)
    `CHK(direct_queue_full, 1'b0)
    pulseDone;
    tick(3);
    `CHK(loads - base, 1)
    motorContinuous = 1'b1;
    host.launch(1'b0);
    tick(3);
    `CHK(execPosition[15:0], 16'h0BBB)
    `CHK(direct_queue_full, 1'b0)
    host.drop(1'b0);
    motorContinuous = 1'b0;
    host.wr(REG_FORWARD, FORWARD_EXEC);
    host.wr(REG_POS_LOW, 16'h0CCC);
    host.launch(1'b0);
    tick(3);
    `CHK(loads - base, 3)
    `CHK(execPosition[15:0], 16'h0CCC)
    $display("test buffer done");
  endtask : t_buffer
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  initial
  begin
    rst = 1'b1;
    trigSelWrEn = 1'b0;
    trigSelWrData = 16'h0000;
    motorIdle = 1'b1;
    motorContinuous = 1'b0;
    motionDone = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset;
    t_edge;
    t_level;
    t_buffer;
    give_verdict;
  end
  // whole run is well under a thousand cycles
  initial
  begin
    #40000;
    fail_count++;
    give_verdict;
  end
endmodule : direct_motion_trigger_queue_tb

// >>> bench/host_model.sv
`timescale 1ns/1ps
module host_model
  import direct_motion_pkg::*;
(
  input  wire logic        clk,
  output logic             regWrEn,
  output logic             regRdEn,
  output logic      [15:0] regAddr,
  output logic      [15:0] regWrData,
  input  wire logic [15:0] regRdData,
  input  wire logic        regRdValid
);
  initial
  begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 16'h0000;
    regWrData = 16'h0000;
  end
  // one word per two cycles, strobe never re-raised in the same step
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(posedge clk);
    #1;
    regWrEn = 1'b0;
    regWrData = ~d;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
    @(posedge clk);
    #1;
    regRdEn = 1'b1;
    regAddr = a;
    @(posedge clk);
    #1;
    regRdEn = 1'b0;
    v = regRdValid;
    d = regRdData;
  endtask : rd
  task automatic readyCheck(output logic r);
    logic [15:0] d;
    logic        v;
    rd(REG_FIXED_OUT, d, v);
    r = d[BIT_DIRECT_CMD_READY];
  endtask : readyCheck
  task automatic launch(input logic style);
    wr(REG_FIXED_IN, {6'h00, style, 1'b1, 8'h00});
  endtask : launch
  // bounded poll, a lost echo must not hang the host
  task automatic drop(input logic style);
    logic [15:0] d;
    logic        v;
    for (int n = 0; n < 8; n++)
    begin
      rd(REG_FIXED_OUT, d, v);
      if (d[BIT_LAUNCH_ECHO] === 1'b1)
        break;
    end
    wr(REG_FIXED_IN, {6'h00, style, 9'h000});
  endtask : drop
endmodule : host_model

// >>> core/direct_motion_pkg.sv
package direct_motion_pkg;
  // register word addresses
  localparam logic [15:0] REG_FIXED_IN    = 16'h0106;
  localparam logic [15:0] REG_MOTION_KIND = 16'h0107;
  localparam logic [15:0] REG_POS_LOW     = 16'h0108;
  localparam logic [15:0] REG_POS_HIGH    = 16'h0109;
  localparam logic [15:0] REG_SPEED_LOW   = 16'h010A;
  localparam logic [15:0] REG_SPEED_HIGH  = 16'h010B;
  localparam logic [15:0] REG_ACCEL_LOW   = 16'h010C;
  localparam logic [15:0] REG_ACCEL_HIGH  = 16'h010D;
  localparam logic [15:0] REG_DECEL_LOW   = 16'h010E;
  localparam logic [15:0] REG_DECEL_HIGH  = 16'h010F;
  localparam logic [15:0] REG_RUN_CURRENT = 16'h0110;
  localparam logic [15:0] REG_FORWARD     = 16'h0111;
  localparam logic [15:0] REG_FIXED_OUT   = 16'h011E;

  // slot indices inside the writable window
  localparam int SLOT_COUNT   = 12;
  localparam int SLOT_FIXED   = 0;
  localparam int SLOT_KIND    = 1;
  localparam int SLOT_POS     = 2;
  localparam int SLOT_SPEED   = 4;
  localparam int SLOT_ACCEL   = 6;
  localparam int SLOT_DECEL   = 8;
  localparam int SLOT_CURRENT = 10;
  localparam int SLOT_FORWARD = 11;

  // fixed input / output bit positions
  localparam int BIT_LAUNCH_STROBE    = 8;
  localparam int BIT_LAUNCH_STYLE     = 9;
  localparam int BIT_DIRECT_CMD_READY = 6;
  localparam int BIT_QUEUE_FULL       = 7;
  localparam int BIT_LAUNCH_ECHO      = 8;

  // trigger select codes, two's complement in 16 bits
  localparam logic [15:0] LAUNCH_STROBE_SEL_KIND    = 16'hFFFA;
  localparam logic [15:0] LAUNCH_STROBE_SEL_POS     = 16'hFFFB;
  localparam logic [15:0] LAUNCH_STROBE_SEL_SPEED   = 16'hFFFC;
  localparam logic [15:0] LAUNCH_STROBE_SEL_ACCEL   = 16'hFFFD;
  localparam logic [15:0] LAUNCH_STROBE_SEL_DECEL   = 16'hFFFE;
  localparam logic [15:0] LAUNCH_STROBE_SEL_CURRENT = 16'hFFFF;
  localparam logic [15:0] LAUNCH_STROBE_SEL_OFF     = 16'h0000;
  localparam logic [15:0] LAUNCH_STROBE_SEL_ANY     = 16'h0001;
  localparam logic [15:0] LAUNCH_STROBE_SEL_RESET   = 16'h0001;

  localparam logic [15:0] KIND_INCREMENTAL_CMD = 16'h0002;
  localparam logic [15:0] FORWARD_EXEC         = 16'h0000;
  localparam logic [15:0] FORWARD_BUFFER       = 16'h0001;

  // reset image of slots 11 down to 0
  localparam logic [SLOT_COUNT*16-1:0] SLOT_RESET_VEC = {
    16'h0000, 16'h03E8, 16'h000F, 16'h4240, 16'h000F, 16'h4240,
    16'h0000, 16'h03E8, 16'h0000, 16'h0000, 16'h0002, 16'h0000};

  // kind16 + pos32 + speed32 + accel32 + decel32 + current16
  localparam int CMD_SET_W = 160;

  // exec set after reset, kind word on top, current word at the bottom
  localparam logic [CMD_SET_W-1:0] EXEC_RESET_SET = {
    16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h03E8,
    16'h000F, 16'h4240, 16'h000F, 16'h4240, 16'h03E8};
endpackage : direct_motion_pkg

// >>> core/direct_motion_trigger_queue.sv
`timescale 1ns/1ps
module direct_motion_trigger_queue
  import direct_motion_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst,
  input  wire logic                 regWrEn,
  input  wire logic                 regRdEn,
  input  wire logic [15:0]          regAddr,
  input  wire logic [15:0]          regWrData,
  output logic      [15:0]          regRdData,
  output logic                      regRdValid,
  input  wire logic                 trigSelWrEn,
  input  wire logic [15:0]          trigSelWrData,
  input  wire logic                 motorIdle,
  input  wire logic                 motorContinuous,
  input  wire logic                 motionDone,
  output logic                      cmdLoad,
  output logic      [15:0]          execKind,
  output logic      [31:0]          execPosition,
  output logic      [31:0]          execSpeed,
  output logic      [31:0]          execAccel,
  output logic      [31:0]          execDecel,
  output logic      [15:0]          execCurrent,
  output logic                      execIncremental,
  output logic                      direct_cmd_ready,
  output logic                      direct_queue_full,
  output logic                      launch_echo
);

  logic [15:0]          slotVal [SLOT_COUNT];
  logic [15:0]          slotPrev [SLOT_COUNT];
  logic [SLOT_COUNT-1:0] slotChg;
  logic [SLOT_COUNT-1:0] slotWr;

  genvar g;
  generate
    for (g = 0; g < SLOT_COUNT; g++)
    begin : gSlot
      assign slotWr[g] = regWrEn && (regAddr == 16'(REG_FIXED_IN + g));
      param_word_tracker #(
        .RESET_VAL (SLOT_RESET_VEC[g*16 +: 16])
      ) uTrack (
        .clk       (clk),
        .rst       (rst),
        .wrEn      (slotWr[g]),
        .wrData    (regWrData),
        .value     (slotVal[g]),
        .prevValue (slotPrev[g]),
        .changed   (slotChg[g])
      );
    end
  endgenerate

  logic [15:0] trigSel_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      trigSel_r <= LAUNCH_STROBE_SEL_RESET;
    else if (trigSelWrEn)
      trigSel_r <= trigSelWrData;
  end

  wire launchBit  = slotVal[SLOT_FIXED][BIT_LAUNCH_STROBE];
  wire launchPrev = slotPrev[SLOT_FIXED][BIT_LAUNCH_STROBE];
  wire launchRise = launchBit && !launchPrev;
  wire levelStyle = slotVal[SLOT_FIXED][BIT_LAUNCH_STYLE];
  wire enabled    = (trigSel_r != LAUNCH_STROBE_SEL_OFF);

  // a 32-bit value changes when either of its halves does
  wire kindChg  = slotChg[SLOT_KIND];
  wire posChg   = slotChg[SLOT_POS] || slotChg[SLOT_POS+1];
  wire spdChg   = slotChg[SLOT_SPEED] || slotChg[SLOT_SPEED+1];
  wire accChg   = slotChg[SLOT_ACCEL] || slotChg[SLOT_ACCEL+1];
  wire decChg   = slotChg[SLOT_DECEL] || slotChg[SLOT_DECEL+1];
  wire curChg   = slotChg[SLOT_CURRENT];
  wire anyChg   = kindChg || posChg || spdChg || accChg || decChg || curChg;

  logic qualChg;
  always_comb
  begin
    case (trigSel_r)
      LAUNCH_STROBE_SEL_ANY:     qualChg = anyChg;
      LAUNCH_STROBE_SEL_KIND:    qualChg = kindChg;
      LAUNCH_STROBE_SEL_POS:     qualChg = posChg;
      LAUNCH_STROBE_SEL_SPEED:   qualChg = spdChg;
      LAUNCH_STROBE_SEL_ACCEL:   qualChg = accChg;
      LAUNCH_STROBE_SEL_DECEL:   qualChg = decChg;
      LAUNCH_STROBE_SEL_CURRENT: qualChg = curChg;
      default:          qualChg = 1'b0;
    endcase
  end

  // level style: entered on the rise, held while the strobe stays high
  logic levelActive_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      levelActive_r <= 1'b0;
    else if (!launchBit || !enabled || !levelStyle)
      levelActive_r <= 1'b0;
    else if (launchRise)
      levelActive_r <= 1'b1;
  end

  // the change is acted on in the cycle it first appears
  wire levelStart = levelStyle && levelActive_r && launchBit && qualChg;
  wire startEvt   = enabled && (launchRise || levelStart);

  // low word at even address, high word at the next
  wire [CMD_SET_W-1:0] liveSet = {
    slotVal[SLOT_KIND],
    slotVal[SLOT_POS+1],   slotVal[SLOT_POS],
    slotVal[SLOT_SPEED+1], slotVal[SLOT_SPEED],
    slotVal[SLOT_ACCEL+1], slotVal[SLOT_ACCEL],
    slotVal[SLOT_DECEL+1], slotVal[SLOT_DECEL],
    slotVal[SLOT_CURRENT]};

  wire fwdBuffer = (slotVal[SLOT_FORWARD] == FORWARD_BUFFER);
  wire bypass    = motorIdle || motorContinuous;

  logic                 full_r;
  logic [CMD_SET_W-1:0] bufSet_r;
  logic [CMD_SET_W-1:0] execSet_r;
  logic                 cmdLoad_r;

  // a draining buffer wins the execution slot over a same-cycle start
  wire drainEvt  = full_r && motionDone;
  wire direct    = startEvt && (!fwdBuffer || bypass) && !drainEvt;
  wire bufLoad   = startEvt && fwdBuffer && !bypass && !full_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      full_r    <= 1'b0;
      bufSet_r  <= '0;
      execSet_r <= EXEC_RESET_SET;
      cmdLoad_r <= 1'b0;
    end
    else
    begin
      cmdLoad_r <= drainEvt || direct;
      if (drainEvt)
        execSet_r <= bufSet_r;
      else if (direct)
        execSet_r <= liveSet;
      if (bufLoad)
        bufSet_r <= liveSet;
      if (bufLoad)
        full_r <= 1'b1;
      else if (drainEvt)
        full_r <= 1'b0;
    end
  end

  logic echo_r;
  always_ff @(posedge clk)
  begin
    if (rst)
      echo_r <= 1'b0;
    else
      echo_r <= launchBit;
  end

  assign cmdLoad         = cmdLoad_r;
  assign execKind        = execSet_r[159:144];
  assign execPosition    = execSet_r[143:112];
  assign execSpeed       = execSet_r[111:80];
  assign execAccel       = execSet_r[79:48];
  assign execDecel       = execSet_r[47:16];
  assign execCurrent     = execSet_r[15:0];
  assign execIncremental = (execKind == KIND_INCREMENTAL_CMD);
  assign direct_queue_full = full_r;
  // ready drops while the trigger select is zero or the queue is full, even if a stopped or continuous motor could take a set directly
  assign direct_cmd_ready  = enabled && !full_r;
  assign launch_echo       = echo_r;

  wire [15:0] outWord = 16'((16'(direct_cmd_ready) << BIT_DIRECT_CMD_READY)
                      | (16'(full_r) << BIT_QUEUE_FULL)
                      | (16'(echo_r) << BIT_LAUNCH_ECHO));

  wire [15:0] rdIdx   = 16'(regAddr - REG_FIXED_IN);
  wire        inSlots = (regAddr >= REG_FIXED_IN) && (regAddr <= REG_FORWARD);
  wire [15:0] rdMux   = inSlots ? slotVal[rdIdx[3:0]] :
                        (regAddr == REG_FIXED_OUT) ? outWord : 16'h0000;

  logic [15:0] rdData_r;
  logic        rdValid_r;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rdData_r  <= 16'h0000;
      rdValid_r <= 1'b0;
    end
    else
    begin
      rdValid_r <= regRdEn;
      if (regRdEn)
        rdData_r <= rdMux;
    end
  end

  assign regRdData  = rdData_r;
  assign regRdValid = rdValid_r;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_disabled_no_load : assert property (
    (!enabled && !drainEvt) |=> !cmdLoad)
    else $error("load while trigger select is zero");

  a_edge_launch_loads : assert property (
    ($rose(launchBit) && enabled && !fwdBuffer && !drainEvt) |=> cmdLoad && execSet_r == $past(liveSet))
    else $error("launch rise did not load the live set");

  a_edge_ignores_data : assert property (
    (!levelStyle && !launchRise && !drainEvt) |=> !cmdLoad)
    else $error("edge style started without a rise");

  a_level_pos_start : assert property (
    (levelStyle && levelActive_r && launchBit && trigSel_r == LAUNCH_STROBE_SEL_POS && posChg
     && !fwdBuffer && !drainEvt) |=> cmdLoad)
    else $error("selected parameter change did not start motion");

  a_other_change_quiet : assert property (
    (trigSel_r == LAUNCH_STROBE_SEL_SPEED && !spdChg && !launchRise && !drainEvt) |=> !cmdLoad)
    else $error("unselected parameter change started motion");

  a_buffer_fill : assert property (
    (startEvt && fwdBuffer && !bypass && !full_r) |=> full_r && !cmdLoad ##1 full_r || $past(motionDone))
    else $error("buffered launch did not fill the queue");

  a_full_refuses : assert property (
    (full_r && !motionDone) |=> full_r && $stable(bufSet_r))
    else $error("buffer changed while full");

  a_drain_on_done : assert property (
    (full_r && motionDone) |=> cmdLoad && !full_r && execSet_r == $past(bufSet_r))
    else $error("completed motion did not start the buffered set");

  a_idle_bypass : assert property (
    (startEvt && motorIdle && !drainEvt) |=> cmdLoad && !full_r || $past(full_r))
    else $error("stopped motor did not take the set directly");

  a_echo_tracks : assert property (
    $changed(launchBit) |=> launch_echo == $past(launchBit))
    else $error("launch echo does not follow the strobe");

  // a full queue must never advertise readiness to the host
  a_full_not_ready : assert property (
    direct_queue_full |-> !direct_cmd_ready)
    else $error("ready shown while queue full");

  a_full_drops_set : assert property (
    (full_r && startEvt && !motionDone && fwdBuffer && !bypass) |=> !cmdLoad && $stable(bufSet_r))
    else $error("launch while full was not refused");

  a_buffer_one_set : assert property (
    bufLoad |=> bufSet_r == $past(liveSet))
    else $error("buffer did not take the whole live set");

  a_level_needs_rise : assert property (
    (!levelActive_r && !launchRise && !drainEvt) |=> !cmdLoad)
    else $error("data change started motion before a rise");

  a_continuous_bypass : assert property (
    (startEvt && motorContinuous && !drainEvt) |=> cmdLoad)
    else $error("continuous motion did not take the set directly");

  a_incr_decode : assert property (
    (cmdLoad && execKind == KIND_INCREMENTAL_CMD) |-> execIncremental)
    else $error("incremental kind not flagged");

  // reads answer one cycle later, the host samples then
  a_read_answer : assert property (
    regRdEn |=> regRdValid)
    else $error("read strobe without a valid answer");

  c_edge_load   : cover property ($rose(launchBit) ##1 cmdLoad);
  c_buffer_fill : cover property (!full_r ##1 full_r ##[1:20] (full_r && motionDone));
  c_level_chg   : cover property (levelStart && trigSel_r == LAUNCH_STROBE_SEL_POS);
  c_refused     : cover property (full_r && startEvt && !motionDone);

endmodule : direct_motion_trigger_queue

// >>> core/param_word_tracker.sv
`timescale 1ns/1ps
module param_word_tracker
  import direct_motion_pkg::*;
#(
  parameter logic [15:0] RESET_VAL = 16'h0000
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wrEn,
  input  wire logic [15:0] wrData,
  output logic      [15:0] value,
  output logic      [15:0] prevValue,
  output logic             changed
);

  logic [15:0] value_r;
  logic [15:0] prev_r;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      value_r <= RESET_VAL;
      prev_r  <= RESET_VAL;
    end
    else
    begin
      if (wrEn)
        value_r <= wrData;
      prev_r <= value_r;
    end
  end

  // an identical rewrite leaves value equal to its image
  assign changed   = (value_r != prev_r);
  assign value     = value_r;
  assign prevValue = prev_r;

  a_write_then_change : assert property (@(posedge clk) disable iff (rst)
    (wrEn && wrData != value_r) |=> changed && value_r == $past(wrData))
    else $error("written word did not show as changed");

endmodule : param_word_tracker
